// file: design/lpbs_ctl_if.sv
// Interface carrying clock-gate and recovery signals between the sequencer modules.
interface lpbs_ctl_if;
    logic       rec_start;
    logic       rec_done;
    logic       short_rec;
    logic       core_en;
    logic       dbl_en;
    logic       quad_en;
    modport seq (output rec_start, output short_rec, output core_en, output dbl_en,
                 output quad_en, input rec_done);
    modport rec (input rec_start, input short_rec, output rec_done);
    modport gate (input core_en, input dbl_en, input quad_en);
endinterface

// file: design/lpbs_pkg.sv
// Package of constants and types for the low-power and break sequencer.
package lpbs_pkg;
    localparam int unsigned CLK_HZ           = 10000000;
    localparam int unsigned REC_LONG_CYCLES  = 4096;
    localparam int unsigned REC_SHORT_CYCLES = 32;
    localparam int unsigned REC_CNT_W        = 13;
    localparam logic [15:0] SWI_VECTOR_ADDR  = 16'hFFFC;
    localparam logic        MASK_RESET_VAL   = 1'h1;

    typedef enum logic [2:0] {
        LPBS_RUN     = 3'h0,
        LPBS_WAIT    = 3'h1,
        LPBS_STOP    = 3'h3,
        LPBS_RECOVER = 3'h2,
        LPBS_BREAK   = 3'h6
    } lpbs_state_t;

    function automatic logic [REC_CNT_W-1:0] lpbs_rec_limit(input logic short_rec);
        lpbs_rec_limit = short_rec ? REC_CNT_W'(REC_SHORT_CYCLES) : REC_CNT_W'(REC_LONG_CYCLES);
    endfunction
endpackage

// file: design/lpbs_recovery.sv
// Stop recovery delay counter running on the quad-rate bus clock.
module lpbs_recovery
    import lpbs_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    lpbs_ctl_if.rec   ctl
);
    logic [REC_CNT_W-1:0] cnt_reg;
    logic [REC_CNT_W-1:0] cnt_next;
    logic                 busy_reg;
    logic                 done_reg;
    wire  logic [REC_CNT_W-1:0] limit = lpbs_rec_limit(ctl.short_rec);
    wire  logic                 hit   = busy_reg && (cnt_reg == limit - REC_CNT_W'(1));

    assign cnt_next     = ctl.rec_start ? '0 : (busy_reg ? cnt_reg + REC_CNT_W'(1) : cnt_reg);
    assign ctl.rec_done = done_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= ctl.rec_start | (busy_reg & ~hit);
            done_reg <= hit & ~ctl.rec_start;
        end
    end

    recovery_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_reg) && ctl.short_rec |-> busy_reg [*8] ##[24:25] done_reg)
        else $error("Short stop recovery did not finish in 32 cycles.");
endmodule

// file: design/lpbs_top.sv
// Low-power mode and break sequencer with flag protection and clock gating.
module lpbs_top
    import lpbs_pkg::*;
#(
    parameter int unsigned FLAG_N = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wait_exec_i,
    input  wire logic              stop_exec_i,
    input  wire logic              irq_i,
    input  wire logic              break_irq_i,
    input  wire logic              break_exit_i,
    input  wire logic              break_flag_clear_enable_i,
    input  wire logic              break_stop_wait_flag_clear_i,
    input  wire logic              watchdog_disable_i,
    input  wire logic              short_stop_recovery_i,
    input  wire logic              osc_keep_in_stop_i,
    input  wire logic              mask_set_i,
    input  wire logic [FLAG_N-1:0] flag_set_i,
    input  wire logic [FLAG_N-1:0] flag_clr_step1_i,
    input  wire logic [FLAG_N-1:0] flag_clr_step2_i,
    output logic [FLAG_N-1:0]      flags_o,
    output logic                   interrupt_mask_o,
    output logic                   core_clk_en_o,
    output logic                   bus_clock_double_en_o,
    output logic                   bus_clock_quad_en_o,
    output logic                   bus_clk_o,
    output logic                   watchdog_run_o,
    output logic                   force_swi_o,
    output logic [15:0]            fetch_addr_o,
    output logic                   stack_start_o,
    output logic                   break_mode_o,
    output logic                   break_stop_wait_flag_o,
    output logic [7:0]             sys_counter_o
);
    lpbs_ctl_if ctl ();

    lpbs_state_t       state_reg;
    lpbs_state_t       state_next;
    logic [FLAG_N-1:0] flags_reg;
    logic [FLAG_N-1:0] armed_reg;
    logic              mask_reg;
    logic              stack_reg;
    logic              swi_reg;
    logic              break_stop_wait_flag_reg;
    logic              core_en_reg;
    logic              dbl_en_reg;
    logic              quad_en_reg;
    logic              wdog_reg;
    logic              rec_start_reg;
    logic [1:0]        div_reg;
    logic [7:0]        sys_cnt_reg;
    // Break status is kept in its own flop so that the pin never shows a state decode.
    logic              brk_reg;

    // Event decoding.
    wire logic in_wait   = (state_reg == LPBS_WAIT);
    wire logic in_stop   = (state_reg == LPBS_STOP);
    wire logic in_break  = (state_reg == LPBS_BREAK);
    wire logic lp_enter  = (state_reg == LPBS_RUN) && (wait_exec_i || stop_exec_i);
    wire logic wait_wake = in_wait && irq_i && !mask_reg;
    wire logic stop_wake = in_stop && irq_i;
    wire logic clr_ok    = !in_break || break_flag_clear_enable_i;

    // A second step completes a clear only if its first step came before;
    // in break with protection on, the completion is simply withheld.
    wire logic [FLAG_N-1:0] step2_ok = flag_clr_step2_i & armed_reg;
    wire logic [FLAG_N-1:0] clr_mask = clr_ok ? step2_ok : '0;
    wire logic [FLAG_N-1:0] flags_next = (flags_reg & ~clr_mask) | flag_set_i;
    wire logic [FLAG_N-1:0] armed_next = (armed_reg | flag_clr_step1_i) & ~clr_mask;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LPBS_RUN: begin
                if (break_irq_i) begin
                    state_next = LPBS_BREAK;
                end else if (stop_exec_i) begin
                    state_next = LPBS_STOP;
                end else if (wait_exec_i) begin
                    state_next = LPBS_WAIT;
                end
            end
            LPBS_WAIT: begin
                if (break_irq_i) begin
                    state_next = LPBS_BREAK;
                end else if (wait_wake) begin
                    state_next = LPBS_RUN;
                end
            end
            LPBS_STOP: begin
                if (break_irq_i) begin
                    state_next = LPBS_BREAK;
                end else if (stop_wake) begin
                    state_next = LPBS_RECOVER;
                end
            end
            LPBS_RECOVER: begin
                if (ctl.rec_done) begin
                    state_next = LPBS_RUN;
                end
            end
            LPBS_BREAK: begin
                if (break_exit_i) begin
                    state_next = LPBS_RUN;
                end
            end
            default: state_next = LPBS_RUN;
        endcase
    end

    wire logic gate_core = (state_next == LPBS_WAIT) || (state_next == LPBS_STOP)
                           || (state_next == LPBS_RECOVER);
    wire logic gate_all  = (state_next == LPBS_STOP) || (state_next == LPBS_RECOVER);
    wire logic mask_next = lp_enter ? 1'b0 : (mask_set_i ? 1'b1 : mask_reg);
    wire logic stack_next = wait_wake
                            || (state_reg == LPBS_RECOVER && ctl.rec_done);
    wire logic break_stop_wait_flag_next = (in_wait && break_irq_i) | (break_stop_wait_flag_reg & ~break_stop_wait_flag_clear_i);

    assign ctl.rec_start = rec_start_reg;
    assign ctl.short_rec = short_stop_recovery_i;
    assign ctl.core_en   = core_en_reg;
    assign ctl.dbl_en    = dbl_en_reg;
    assign ctl.quad_en   = quad_en_reg;

    lpbs_recovery u_rec (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ctl   (ctl.rec)
    );

    // Every reset source is merged onto rst_i before it arrives here, so no
    // source can be favoured over another.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= LPBS_RUN;
            flags_reg     <= '0;
            armed_reg     <= '0;
            mask_reg      <= MASK_RESET_VAL;
            stack_reg     <= 1'b0;
            swi_reg       <= 1'b0;
            break_stop_wait_flag_reg      <= 1'b0;
            core_en_reg   <= 1'b1;
            dbl_en_reg    <= 1'b1;
            quad_en_reg   <= 1'b1;
            wdog_reg      <= 1'b0;
            rec_start_reg <= 1'b0;
            brk_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            flags_reg     <= flags_next;
            armed_reg     <= armed_next;
            mask_reg      <= mask_mux(mask_next, stack_next);
            stack_reg     <= stack_next;
            swi_reg       <= break_irq_i && !in_break;
            break_stop_wait_flag_reg      <= break_stop_wait_flag_next;
            core_en_reg   <= !gate_core;
            dbl_en_reg    <= !gate_all || osc_keep_in_stop_i;
            quad_en_reg   <= !gate_all;
            wdog_reg      <= !watchdog_disable_i && !gate_all;
            rec_start_reg <= stop_wake;
            brk_reg       <= (state_next == LPBS_BREAK);
        end
    end

    // Taking the interrupt sets the mask again, as vector entry does.
    function automatic logic mask_mux(input logic m, input logic stk);
        mask_mux = stk ? 1'b1 : m;
    endfunction

    // Bus clock made from the double rate clock by a further divide by two.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg     <= '0;
            sys_cnt_reg <= '0;
        end else begin
            div_reg     <= div_reg + 2'h1;
            sys_cnt_reg <= (state_next == LPBS_STOP) ? 8'h00 : sys_cnt_reg + 8'h01;
        end
    end

    // this module and the recovery counter run on the quad-rate clock.
    assign flags_o                = flags_reg;
    assign interrupt_mask_o       = mask_reg;
    assign core_clk_en_o          = core_en_reg;
    assign bus_clock_double_en_o  = dbl_en_reg;
    assign bus_clock_quad_en_o    = quad_en_reg;
    assign bus_clk_o              = div_reg[1];
    assign watchdog_run_o         = wdog_reg;
    assign force_swi_o            = swi_reg;
    assign fetch_addr_o           = SWI_VECTOR_ADDR;
    assign stack_start_o          = stack_reg;
    assign break_mode_o           = brk_reg;
    assign break_stop_wait_flag_o = break_stop_wait_flag_reg;
    assign sys_counter_o          = sys_cnt_reg;

    flag_protect_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_break && !break_flag_clear_enable_i
        |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
        else $error("Flag cleared during protected break.");

    mask_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lp_enter && !stack_next |=> !mask_reg)
        else $error("Interrupt mask not cleared on low-power entry.");

    wait_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_wait |-> !core_en_reg && quad_en_reg)
        else $error("Wait mode clock gating wrong.");

    wait_stack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wait_wake && !break_irq_i |=> stack_reg && state_reg == LPBS_RUN)
        else $error("Wait wake did not stack one cycle later.");

    break_break_stop_wait_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_wait && break_irq_i |=> break_stop_wait_flag_reg && in_break)
        else $error("Break in wait did not set stop/wait flag.");

    stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_stop |-> !quad_en_reg && sys_cnt_reg == 8'h00
        && dbl_en_reg == $past(osc_keep_in_stop_i))
        else $error("Stop mode clocks not gated.");

    stop_recover_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_wake && !break_irq_i |=> !stack_reg [*8])
        else $error("Stacking began before stop recovery.");

    watchdog_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_wait && !$past(watchdog_disable_i) && $past(in_wait) |-> wdog_reg)
        else $error("Watchdog stopped during wait.");

    // A break taken from run, wait or stop redirects the fetch.
    swi_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        break_irq_i && (state_reg == LPBS_RUN || in_wait || in_stop) |=> swi_reg && brk_reg)
        else $error("Break entry did not force the software interrupt fetch.");

    // Leaving break must not bring back a flag that was cleared inside it.
    flag_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_break && break_exit_i |=> (flags_reg & ~$past(flags_reg | flag_set_i)) == '0)
        else $error("Flag restored on break exit.");

    step2_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_break |=> (flags_reg & $past(flag_clr_step2_i & armed_reg & ~flag_set_i)) == '0)
        else $error("Second clear step did not clear the flag.");

    // The first step must survive a protected break so the second step works afterwards.
    armed_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_break && !break_flag_clear_enable_i
        |=> ((armed_reg & $past(armed_reg)) == $past(armed_reg)))
        else $error("First clear step lost during protected break.");

    periph_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_wait |-> dbl_en_reg)
        else $error("Peripheral clock stopped in wait.");

    core_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_stop || (state_reg == LPBS_RECOVER) |-> !core_en_reg)
        else $error("Core clocked during stop or recovery.");

    rec_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_wake && !break_irq_i |=> rec_start_reg && (state_reg == LPBS_RECOVER))
        else $error("Recovery counter not started on stop wake.");

    // Core and quad-rate clocks stay gated for as long as the recovery count is still running.
    rec_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == LPBS_RECOVER) && !ctl.rec_done |=> !quad_en_reg && !core_en_reg)
        else $error("Clocks enabled before recovery completed.");

    sys_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == LPBS_RUN) && (state_next == LPBS_RUN)
        |=> sys_cnt_reg == $past(sys_cnt_reg) + 8'h01)
        else $error("System counter did not advance while running.");

    bus_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> div_reg == $past(div_reg) + 2'h1)
        else $error("Bus clock divider did not advance.");

    wdog_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        in_stop |-> !wdog_reg)
        else $error("Watchdog clock running in stop.");

    // Stacking is a single strobe; a held strobe would stack the core twice.
    stack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        stack_reg |=> !stack_reg)
        else $error("Stacking strobe held longer than one cycle.");
endmodule

// file: verification/lpbs_core_model.sv
// Behavioural model of the core and a peripheral that issue low-power instructions and wakes.
module lpbs_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] lp_cmd_i,
    input  wire logic [3:0] irq_delay_i,
    input  wire logic       core_clk_en_i,
    input  wire logic       stack_start_i,
    output logic            wait_exec_o,
    output logic            stop_exec_o,
    output logic            irq_o
);
    logic [3:0] delay_reg;

    // The wake request is held until stacking begins, as a real module keeps its flag set.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_exec_o <= 1'h0;
            stop_exec_o <= 1'h0;
            irq_o       <= 1'h0;
            delay_reg   <= 4'h0;
        end else begin
            wait_exec_o <= (lp_cmd_i == 2'h1);
            stop_exec_o <= (lp_cmd_i == 2'h2);
            if (stack_start_i) begin
                irq_o     <= 1'h0;
                delay_reg <= 4'h0;
            end else if (!core_clk_en_i && irq_delay_i != 4'h0) begin
                delay_reg <= delay_reg + 4'h1;
                if (delay_reg == irq_delay_i) begin
                    irq_o <= 1'h1;
                end
            end
        end
    end
endmodule

// file: verification/testbench.sv
// Self-checking testbench for the low-power and break sequencer.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lpbs_pkg::*;
    localparam int FN = 8;
    logic          clk_i = 1'h0;
    logic          rst_i = 1'h1;
    logic [4:0]    ctl = 5'h0;
    logic [3:0]    irq_delay = 4'h0;
    logic          break_flag_clear_enable = 1'h0;
    logic          wd_dis = 1'h0;
    logic          ssr = 1'h1;
    logic          osc_keep = 1'h0;
    logic [FN-1:0] fset = '0;
    logic [FN-1:0] fclr1 = '0;
    logic [FN-1:0] fclr2 = '0;
    logic [FN-1:0] flags, fexp;
    logic          wexec, sexec, irq, mask, core_en, dbl_en, quad_en, wd_run, software_interrupt_vector, stack;
    logic          brk_mode, bsw_flag, early, swi_seen = 1'h0;
    logic [15:0]   fetch;
    logic [7:0]    sys_cnt;
    logic          bus_clk;
    logic [7:0]    bc;
    int            bad_count = 0;
    int            tests_run = 0;
    int            cycles = 0;
    int            seed = 32'hf6d0e229;
    int            n, lim;

    lpbs_core_model lpbs_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .lp_cmd_i(ctl[4:3]),
        .irq_delay_i(irq_delay), .core_clk_en_i(core_en), .stack_start_i(stack),
        .wait_exec_o(wexec), .stop_exec_o(sexec), .irq_o(irq));
    lpbs_top #(.FLAG_N(FN)) lpbs_top_i (.clk_i(clk_i), .rst_i(rst_i), .wait_exec_i(wexec),
        .stop_exec_i(sexec), .irq_i(irq), .break_irq_i(ctl[2]), .break_exit_i(ctl[1]),
        .break_flag_clear_enable_i(break_flag_clear_enable), .break_stop_wait_flag_clear_i(ctl[0]), .watchdog_disable_i(wd_dis),
        .short_stop_recovery_i(ssr), .osc_keep_in_stop_i(osc_keep), .mask_set_i(1'h0),
        .flag_set_i(fset), .flag_clr_step1_i(fclr1), .flag_clr_step2_i(fclr2), .flags_o(flags),
        .interrupt_mask_o(mask), .core_clk_en_o(core_en), .bus_clock_double_en_o(dbl_en),
        .bus_clock_quad_en_o(quad_en), .bus_clk_o(bus_clk), .watchdog_run_o(wd_run),
        .force_swi_o(software_interrupt_vector), .fetch_addr_o(fetch), .stack_start_o(stack),
        .break_mode_o(brk_mode), .break_stop_wait_flag_o(bsw_flag), .sys_counter_o(sys_cnt));

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles++;
        if (software_interrupt_vector === 1'h1) swi_seen <= 1'h1;
        if (cycles == 12000) begin
            bad_count++;
            report_and_stop();
        end
    end

    function automatic int rec_len(input logic short_rec);
        return short_rec ? REC_SHORT_CYCLES : REC_LONG_CYCLES;
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Drive flag strobes for exactly one sampled edge, then settle before any comparison.
    task automatic pulse_flags(input logic [FN-1:0] s, input logic [FN-1:0] c1,
                               input logic [FN-1:0] c2);
        @(posedge clk_i);
        fset <= s;
        fclr1 <= c1;
        fclr2 <= c2;
        @(posedge clk_i);
        fset <= '0;
        fclr1 <= '0;
        fclr2 <= '0;
        #1;
    endtask

    // Control vector: low-power command, break request, break exit, break flag clear.
    task automatic pulse_ctl(input logic [4:0] v);
        @(posedge clk_i);
        ctl <= v;
        @(posedge clk_i);
        ctl <= 5'h0;
        #1;
    endtask

    task automatic wait_core(input logic lvl);
        n = 0;
        while (core_en !== lvl && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        check("mask_rst", 16'h1, mask);
        check("clk_en_rst", 16'h7, {core_en, dbl_en, quad_en});
        check("flags_rst", 16'h0, flags);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            #1;
            bc[k] = bus_clk;
        end
        check("bus_clk", 16'h0066, {8'h00, bc});
        fexp = FN'($random(seed)) | FN'(3);
        pulse_flags(fexp, '0, '0);
        pulse_flags('0, FN'(1), '0);
        pulse_ctl(5'h04);
        repeat (3) @(posedge clk_i);
        #1;
        check("swi", 16'h1, swi_seen);
        check("fetch", SWI_VECTOR_ADDR, fetch);
        check("brk", 16'h1, brk_mode);
        pulse_flags('0, '0, '1);
        check("flags_guard", 16'(fexp), 16'(flags));
        break_flag_clear_enable <= 1'h1;
        pulse_flags('0, FN'(2), '0);
        pulse_flags('0, '0, FN'(2));
        fexp = fexp & ~FN'(2);
        check("flags_clr_brk", 16'(fexp), 16'(flags));
        break_flag_clear_enable <= 1'h0;
        pulse_ctl(5'h02);
        repeat (2) @(posedge clk_i);
        #1;
        check("flags_after_brk", 16'(fexp), 16'(flags));
        pulse_flags('0, '0, FN'(1));
        fexp = fexp & ~FN'(1);
        check("flags_step2", 16'(fexp), 16'(flags));
        // Wait with a wake request from a peripheral.
        wd_dis <= 1'($random(seed));
        irq_delay <= 4'h3;
        pulse_ctl(5'h08);
        wait_core(1'h0);
        check("wait_mask", 16'h0, mask);
        check("wait_gate", 16'h3, {core_en, dbl_en, quad_en});
        check("wait_wdog", {15'h0, !wd_dis}, {15'h0, wd_run});
        while (irq !== 1'h1 && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
        #1;
        check("wait_stack", 16'h1, stack);
        check("wait_wake", 16'h1, core_en);
        // Stop with short then full recovery; full recovery is the crystal setting.
        for (int s = 1; s >= 0; s--) begin
            ssr <= 1'(s);
            osc_keep <= 1'($random(seed));
            irq_delay <= 4'h5;
            pulse_ctl(5'h10);
            wait_core(1'h0);
            lim = rec_len(1'(s));
            check("stop_gate", {14'h0, osc_keep, 1'b0}, {14'h0, dbl_en, quad_en});
            check("stop_cnt", 16'h0, sys_cnt);
            check("stop_mask", 16'h0, mask);
            while (irq !== 1'h1 && n < 100) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            n = 0;
            early = 1'h0;
            while (stack !== 1'h1 && n < 5000) begin
                if (n < lim - 1 && quad_en !== 1'h0) early = 1'h1;
                @(posedge clk_i);
                #1;
                n++;
            end
            check("rec_gate", 16'h0, early);
            check("rec_len", 16'h1, (n >= lim && n <= lim + 3));
        end
        // Break arriving in wait, then the break flag cleared again.
        irq_delay <= 4'h0;
        pulse_ctl(5'h08);
        wait_core(1'h0);
        pulse_ctl(5'h04);
        repeat (2) @(posedge clk_i);
        #1;
        check("bsw_set", 16'h1, bsw_flag);
        check("brk_wait", 16'h1, brk_mode);
        pulse_ctl(5'h02);
        pulse_ctl(5'h01);
        check("bsw_clr", 16'h0, bsw_flag);
        // Reset in the middle of stop overrides everything at once.
        pulse_ctl(5'h10);
        wait_core(1'h0);
        @(posedge clk_i);
        rst_i <= 1'h1;
        #1;
        check("rst_stop", 16'hF, {mask, core_en, dbl_en, quad_en});
        @(posedge clk_i);
        rst_i <= 1'h0;
        report_and_stop();
    end
endmodule
